// File: hdl/dma_ctrl.v
// How it works
// - The data size bit sets item width only, and bytes travel on the lane of their address.
// - With 16-bit items the start address has its lowest bit forced to zero.
// - The terminal count flag is read-only: writes never set it, but an init write or a fresh enable clears it.
// - The init and trigger bits act on write and always read as zero.
// - Writing the init bit returns the channel to a disabled, idle state.
// - When the count is exhausted the flag sets and the channel stays disabled.
// - At terminal count enable clears one cycle before the flag sets.
`timescale 1ns/1ns
`include "dma_defs.vh"

module dma_ctrl #(
    parameter NCH    = 4,
    parameter ADDR_W = 26
) (
    input  wire              hclk,      // System clock
    input  wire              hresetn,   // Async reset, low
    input  wire              hsel,      // Slave select
    input  wire [31:0]       haddr,     // Byte address
    input  wire [1:0]        htrans,    // Transfer type
    input  wire              hwrite,    // Write when high
    input  wire [2:0]        hsize,     // Word only
    input  wire [31:0]       hwdata,    // Write data
    input  wire              hready,    // Bus ready
    output reg  [31:0]       hrdata,    // Read data
    output wire              hreadyout, // Slave ready
    output wire              hresp,     // Always OKAY
    input  wire [NCH-1:0]    dma_req,   // Hardware request pulses
    output wire              irq,       // Level interrupt
    output reg               mem_req,   // Internal bus request
    output reg               mem_write, // Internal bus write
    output reg  [ADDR_W-1:0] mem_addr,  // Internal bus byte address
    output reg               mem_size,  // 1 = 16-bit item
    output reg  [15:0]       mem_wdata, // Internal bus write data
    input  wire [15:0]       mem_rdata, // Internal bus read data
    input  wire              mem_ready  // Internal bus done
);
    reg              ap_valid_reg, ap_write_reg, rd_wait_reg;
    reg [6:0]        ap_addr_reg;
    reg [NCH-1:0]    stat_reg, mask_reg;
    reg [1:0]        state_reg;
    reg [1:0]        grant_reg;
    reg [1:0]        pick;
    reg              any_pend;
    reg [15:0]       rd_mux;
    reg [15:0]       item_data;

    wire [NCH-1:0]        pend, wide, tc_set, item_done;
    wire [NCH*ADDR_W-1:0] src_all, dst_all;
    wire [NCH*16-1:0]     rdata_all;
    wire                  glb;
    wire [1:0]            ap_ch;
    wire [2:0]            ap_idx;
    wire                  wr_phase;

    assign hresp     = 1'b0;
    assign hreadyout = ~rd_wait_reg;
    assign irq       = |(stat_reg & mask_reg);
    assign glb       = ap_addr_reg[5];
    assign ap_ch     = ap_addr_reg[4:3];
    assign ap_idx    = ap_addr_reg[2:0];
    assign wr_phase  = ap_valid_reg & ap_write_reg;

    // Address phase capture; reads take one wait state so that a write
    // just before is already visible in the returned word
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ap_valid_reg <= 1'b0;
            ap_write_reg <= 1'b0;
            ap_addr_reg  <= 7'h00;
            rd_wait_reg  <= 1'b0;
            hrdata       <= 32'h0000_0000;
        end else begin
            if (hready) begin
                ap_valid_reg <= hsel & htrans[1];
                ap_write_reg <= hwrite;
                ap_addr_reg  <= haddr[8:2];
                rd_wait_reg  <= hsel & htrans[1] & ~hwrite;
            end else begin
                rd_wait_reg  <= 1'b0;
            end
            if (rd_wait_reg)
                hrdata <= {16'h0000, rd_mux};
        end
    end

    // Read mux; anything unmapped reads as zero
    always @* begin
        rd_mux = 16'h0000;
        if (ap_addr_reg[6]) begin
            rd_mux = 16'h0000;
        end else if (glb) begin
            if (ap_idx == `GIX_IRQ_STAT)
                rd_mux = {{(16-NCH){1'b0}}, stat_reg};
            else if (ap_idx == `GIX_IRQ_MASK)
                rd_mux = {{(16-NCH){1'b0}}, mask_reg};
        end else begin
            rd_mux = rdata_all[ap_ch*16 +: 16];
        end
    end

    // Interrupt status: write one to clear, a new event wins over the clear
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            stat_reg <= {NCH{1'b0}};
            mask_reg <= {NCH{1'b0}};
        end else begin
            if (wr_phase && glb && !ap_addr_reg[6] && ap_idx == `GIX_IRQ_MASK)
                mask_reg <= hwdata[NCH-1:0];
            if (wr_phase && glb && !ap_addr_reg[6] && ap_idx == `GIX_IRQ_STAT)
                stat_reg <= (stat_reg & ~hwdata[NCH-1:0]) | tc_set;
            else
                stat_reg <= stat_reg | tc_set;
        end
    end

    // One register set per channel
    genvar g;
    generate
        for (g = 0; g < NCH; g = g + 1) begin : chan
            dma_chan #(
                .ADDR_W (ADDR_W)
            ) u_chan (
                .hclk      (hclk),
                .hresetn   (hresetn),
                .wr_en     (wr_phase && !glb && !ap_addr_reg[6] && ap_ch == g),
                .wr_idx    (ap_idx),
                .wdata     (hwdata[15:0]),
                .rd_idx    (ap_idx),
                .rdata     (rdata_all[g*16 +: 16]),
                .hw_req    (dma_req[g]),
                .item_done (item_done[g]),
                .pending   (pend[g]),
                .src_cur   (src_all[g*ADDR_W +: ADDR_W]),
                .dst_cur   (dst_all[g*ADDR_W +: ADDR_W]),
                .wide      (wide[g]),
                .tc_set    (tc_set[g])
            );
            assign item_done[g] = (state_reg == `ST_WR) && mem_ready && (grant_reg == g);
        end
    endgenerate

    // Fixed priority, channel 0 highest
    integer i;
    always @* begin
        pick     = 2'h0;
        any_pend = 1'b0;
        for (i = NCH - 1; i >= 0; i = i - 1) begin
            if (pend[i]) begin
                pick     = i[1:0];
                any_pend = 1'b1;
            end
        end
    end

    // Byte travels on the lane its address selects, not always the low one
    always @* begin
        if (mem_size)
            item_data = mem_rdata;
        else if (mem_addr[0])
            item_data = {8'h00, mem_rdata[15:8]};
        else
            item_data = {8'h00, mem_rdata[7:0]};
    end

    // Item sequencer: read the source, then write the destination
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_reg <= `ST_IDLE;
            grant_reg <= 2'h0;
            mem_req   <= 1'b0;
            mem_write <= 1'b0;
            mem_addr  <= {ADDR_W{1'b0}};
            mem_size  <= 1'b0;
            mem_wdata <= 16'h0000;
        end else begin
            case (state_reg)
                `ST_IDLE: begin
                    if (any_pend) begin
                        grant_reg <= pick;
                        mem_req   <= 1'b1;
                        mem_write <= 1'b0;
                        mem_addr  <= src_all[pick*ADDR_W +: ADDR_W];
                        mem_size  <= wide[pick];
                        state_reg <= `ST_RD;
                    end
                end
                `ST_RD: begin
                    if (mem_ready) begin
                        mem_write <= 1'b1;
                        mem_addr  <= dst_all[grant_reg*ADDR_W +: ADDR_W];
                        if (mem_size || !dst_all[grant_reg*ADDR_W])
                            mem_wdata <= item_data;
                        else
                            mem_wdata <= {item_data[7:0], 8'h00};
                        state_reg <= `ST_WR;
                    end
                end
                `ST_WR: begin
                    if (mem_ready) begin
                        mem_req   <= 1'b0;
                        mem_write <= 1'b0;
                        state_reg <= `ST_IDLE;
                    end
                end
                default: begin
                    mem_req   <= 1'b0;
                    state_reg <= `ST_IDLE;
                end
            endcase
        end
    end
endmodule

// File: hdl/dma_defs.vh
`ifndef DMA_DEFS_VH
`define DMA_DEFS_VH

// Register index = haddr[4:2], channel = haddr[6:5], global block when haddr[7]
`define RIX_SRC_LO   3'h0
`define RIX_SRC_HI   3'h1
`define RIX_DST_LO   3'h2
`define RIX_DST_HI   3'h3
`define RIX_COUNT    3'h4
`define RIX_ADCTRL   3'h5
`define RIX_CHCTRL   3'h6
`define GIX_IRQ_STAT 3'h0
`define GIX_IRQ_MASK 3'h1

// Addressing control fields
`define ADC_DS       14
`define ADC_SAD_LO   6
`define ADC_DAD_LO   4
`define ADC_WMASK    16'h40f0
`define AM_INC       2'h0
`define AM_DEC       2'h1
`define AM_FIX       2'h2

// Channel control fields
`define CHC_EN       0
`define CHC_STG      1
`define CHC_INIT     2
`define CHC_TC       7

// Reset values
`define RST_HALF     16'h0000

// Sequencer states
`define ST_IDLE      2'h0
`define ST_RD        2'h1
`define ST_WR        2'h2

`endif

// File: hdl/dma_chan.v
`timescale 1ns/1ns
`include "dma_defs.vh"

module dma_chan #(
    parameter ADDR_W = 26
) (
    input  wire              hclk,      // System clock
    input  wire              hresetn,   // Async reset, low
    input  wire              wr_en,     // Register write strobe
    input  wire [2:0]        wr_idx,    // Register index written
    input  wire [15:0]       wdata,     // Write data
    input  wire [2:0]        rd_idx,    // Register index read
    output reg  [15:0]       rdata,     // Read data
    input  wire              hw_req,    // Hardware transfer request pulse
    input  wire              item_done, // One item moved
    output wire              pending,   // Request waiting for the bus
    output wire [ADDR_W-1:0] src_cur,   // Current source address
    output wire [ADDR_W-1:0] dst_cur,   // Current destination address
    output wire              wide,      // 16-bit items
    output wire              tc_set     // Terminal count flag sets now
);
    localparam HW = ADDR_W - 16;

    reg [15:0]       sal_reg, dal_reg, cnt_reg, adc_reg, cnt_cur_reg;
    reg [HW-1:0]     sah_reg, dah_reg;
    reg              en_reg, tc_reg, tc_pend_reg, pend_reg;
    reg [ADDR_W-1:0] src_reg, dst_reg;
    reg [ADDR_W-1:0] src_next, dst_next;

    assign pending = pend_reg;
    assign src_cur = src_reg;
    assign dst_cur = dst_reg;
    assign wide    = adc_reg[`ADC_DS];
    assign tc_set  = tc_pend_reg;

    // Address stepping after each item
    function [ADDR_W-1:0] step;
        input [ADDR_W-1:0] a;
        input [1:0]        mode;
        input              w;
        begin
            case (mode)
                `AM_INC: step = a + {{(ADDR_W-2){1'b0}}, w, ~w};
                `AM_DEC: step = a - {{(ADDR_W-2){1'b0}}, w, ~w};
                default: step = a;
            endcase
        end
    endfunction

    // Start address, odd start forced even for 16-bit items
    always @* begin
        src_next = {sah_reg, sal_reg};
        dst_next = {dah_reg, dal_reg};
        src_next[0] = sal_reg[0] & ~adc_reg[`ADC_DS];
        dst_next[0] = dal_reg[0] & ~adc_reg[`ADC_DS];
    end

    // Channel state; later assignments win, so sets follow clears, except the init clears of pend_reg and tc_pend_reg
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sal_reg     <= `RST_HALF;
            dal_reg     <= `RST_HALF;
            sah_reg     <= {HW{1'b0}};
            dah_reg     <= {HW{1'b0}};
            cnt_reg     <= `RST_HALF;
            adc_reg     <= `RST_HALF;
            cnt_cur_reg <= `RST_HALF;
            en_reg      <= 1'b0;
            tc_reg      <= 1'b0;
            tc_pend_reg <= 1'b0;
            pend_reg    <= 1'b0;
            src_reg     <= {ADDR_W{1'b0}};
            dst_reg     <= {ADDR_W{1'b0}};
        end else begin
            tc_pend_reg <= 1'b0;
            if (item_done) begin
                pend_reg <= 1'b0;
                src_reg  <= step(src_reg, adc_reg[`ADC_SAD_LO+1:`ADC_SAD_LO], wide);
                dst_reg  <= step(dst_reg, adc_reg[`ADC_DAD_LO+1:`ADC_DAD_LO], wide);
                if (cnt_cur_reg == 16'h0000) begin
                    en_reg      <= 1'b0;
                    tc_pend_reg <= 1'b1;
                end else begin
                    cnt_cur_reg <= cnt_cur_reg - 16'h0001;
                end
            end
            if (hw_req && en_reg)
                pend_reg <= 1'b1;
            if (wr_en) begin
                case (wr_idx)
                    `RIX_SRC_LO: sal_reg <= wdata;
                    `RIX_SRC_HI: sah_reg <= wdata[HW-1:0];
                    `RIX_DST_LO: dal_reg <= wdata;
                    `RIX_DST_HI: dah_reg <= wdata[HW-1:0];
                    `RIX_COUNT:  cnt_reg <= wdata;
                    `RIX_ADCTRL: adc_reg <= wdata & `ADC_WMASK;
                    `RIX_CHCTRL: begin
                        if (wdata[`CHC_INIT]) begin
                            en_reg      <= 1'b0;
                            tc_reg      <= 1'b0;
                            tc_pend_reg <= 1'b0;
                            pend_reg    <= 1'b0;
                        end else begin
                            en_reg <= wdata[`CHC_EN];
                            if (wdata[`CHC_EN] && !en_reg) begin
                                src_reg     <= src_next;
                                dst_reg     <= dst_next;
                                cnt_cur_reg <= cnt_reg;
                                tc_reg      <= 1'b0;
                            end
                            if (wdata[`CHC_STG] && wdata[`CHC_EN])
                                pend_reg <= 1'b1;
                        end
                    end
                    default: ;
                endcase
            end
            if (tc_pend_reg)
                tc_reg <= 1'b1;
        end
    end

    // Read view; init and trigger read as zero, flag only from hardware
    always @* begin
        case (rd_idx)
            `RIX_SRC_LO: rdata = sal_reg;
            `RIX_SRC_HI: rdata = {{(16-HW){1'b0}}, sah_reg};
            `RIX_DST_LO: rdata = dal_reg;
            `RIX_DST_HI: rdata = {{(16-HW){1'b0}}, dah_reg};
            `RIX_COUNT:  rdata = cnt_reg;
            `RIX_ADCTRL: rdata = adc_reg;
            `RIX_CHCTRL: rdata = {8'h00, tc_reg, 6'h00, en_reg};
            default:     rdata = 16'h0000;
        endcase
    end
endmodule

// File: tb/mem_model.sv
`timescale 1ns/1ns
module mem_model (
    input  logic        hclk,      // Clock
    input  logic        mem_req,   // Access request
    input  logic        mem_write, // Write access
    input  logic [25:0] mem_addr,  // Byte address
    input  logic        mem_size,  // 16-bit item
    input  logic [15:0] mem_wdata, // Write data
    output logic [15:0] mem_rdata, // Read data
    output logic        mem_ready  // Access done
);
    logic [7:0] mem [0:1023];
    logic [1:0] wait_cnt;
    logic       slow;
    logic [9:0] a;
    assign a = mem_addr[9:0];
    // Known pattern so copied bytes can be predicted
    initial begin
        for (int i = 0; i < 1024; i++)
            mem[i] = i[7:0] ^ 8'h5a;
        wait_cnt = 2'h0;
        slow = 1'b0;
        mem_ready = 1'b0;
        mem_rdata = 16'h0000;
    end
    // Alternate prompt and slow answers; the data bus garbles outside a read reply
    always @(posedge hclk) begin
        mem_ready <= 1'b0;
        mem_rdata <= ~mem_rdata;
        if (mem_req && !mem_ready) begin
            if (wait_cnt != 2'h0) begin
                wait_cnt <= wait_cnt - 2'h1;
            end else begin
                mem_ready <= 1'b1;
                slow      <= ~slow;
                wait_cnt  <= slow ? 2'h0 : 2'h2;
                if (mem_write && mem_size) begin
                    mem[{a[9:1], 1'b0}] <= mem_wdata[7:0];
                    mem[{a[9:1], 1'b1}] <= mem_wdata[15:8];
                end else if (mem_write) begin
                    mem[a] <= a[0] ? mem_wdata[15:8] : mem_wdata[7:0];
                end else if (mem_size) begin
                    mem_rdata <= {mem[{a[9:1], 1'b1}], mem[{a[9:1], 1'b0}]};
                end else begin
                    mem_rdata <= a[0] ? {mem[a], 8'hc3} : {8'h3c, mem[a]};
                end
            end
        end
    end
endmodule

// File: tb/dma_ctrl_assertions.sv
`timescale 1ns/1ns
module dma_ctrl_assertions #(
    parameter NCH    = 4,
    parameter ADDR_W = 26
) (
    input logic              hclk,      // Clock
    input logic              hresetn,   // Reset, low
    input logic              hsel,      // Select
    input logic [31:0]       haddr,     // Address
    input logic [1:0]        htrans,    // Transfer type
    input logic              hwrite,    // Write
    input logic [2:0]        hsize,     // Size
    input logic [31:0]       hwdata,    // Write data
    input logic              hready,    // Bus ready
    input logic [31:0]       hrdata,    // Read data
    input logic              hreadyout, // Slave ready
    input logic              hresp,     // Response
    input logic [NCH-1:0]    dma_req,   // Requests
    input logic              irq,       // Interrupt
    input logic              mem_req,   // Item request
    input logic              mem_write, // Item write
    input logic [ADDR_W-1:0] mem_addr,  // Item address
    input logic              mem_size,  // 16-bit item
    input logic [15:0]       mem_wdata, // Item data out
    input logic [15:0]       mem_rdata, // Item data in
    input logic              mem_ready  // Item done
);
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    okay_resp_a: assert property (hresp == 1'b0)
        else $error("response not okay");
    rd_stall_a: assert property (hsel && htrans[1] && hready && !hwrite
        |=> !hreadyout ##1 hreadyout) else $error("read stall not one cycle");
    wr_nostall_a: assert property (hsel && htrans[1] && hready && hwrite
        |=> hreadyout) else $error("write stalled");
    req_hold_a: assert property (mem_req && !mem_ready
        |=> mem_req && $stable(mem_addr) && $stable(mem_write) && $stable(mem_size))
        else $error("item request dropped or changed");
    even_start_a: assert property (mem_req && mem_size |-> !mem_addr[0])
        else $error("16-bit item on odd address");
    lane_zero_a: assert property (mem_req && mem_write && !mem_size
        |-> (mem_addr[0] ? mem_wdata[7:0] : mem_wdata[15:8]) == 8'h00)
        else $error("unused byte lane not zero");
    rd_then_wr_a: assert property (mem_req && !mem_write && mem_ready
        |=> mem_req && mem_write) else $error("read not followed by write");
    item_gap_a: assert property (mem_req && mem_write && mem_ready |=> !mem_req)
        else $error("no idle cycle after item");
endmodule

// File: tb/dma_channel_config_control_bench.sv
`timescale 1ns/1ns
module dma_channel_config_control_bench;
    logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp, irq;
    logic [31:0] haddr, hwdata, hrdata;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic [3:0]  dma_req;
    logic        mem_req, mem_write, mem_size, mem_ready;
    logic [25:0] mem_addr;
    logic [15:0] mem_wdata, mem_rdata;
    int          mismatches, n_checks;

    dma_ctrl u_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .dma_req(dma_req), .irq(irq), .mem_req(mem_req), .mem_write(mem_write),
        .mem_addr(mem_addr), .mem_size(mem_size), .mem_wdata(mem_wdata),
        .mem_rdata(mem_rdata), .mem_ready(mem_ready));
    mem_model u_mem (.hclk(hclk), .mem_req(mem_req), .mem_write(mem_write),
        .mem_addr(mem_addr), .mem_size(mem_size), .mem_wdata(mem_wdata),
        .mem_rdata(mem_rdata), .mem_ready(mem_ready));

    // 10 MHz clock
    initial begin
        hclk = 1'b0;
        forever #50 hclk = ~hclk;
    end

    task summarize;
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    task chk(input logic [15:0] got, input logic [15:0] exp, input string what);
        n_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    // Single AHB transfers; the bus waits as long as the slave stalls
    task ahb_wr(input logic [31:0] a, input logic [15:0] d);
        @(posedge hclk);
        hsel <= 1'b1;
        haddr <= a;
        hwrite <= 1'b1;
        htrans <= 2'b10;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= {16'h0000, d};
        do @(posedge hclk); while (hreadyout !== 1'b1);
    endtask

    task ahb_rd(input logic [31:0] a, output logic [15:0] d);
        @(posedge hclk);
        hsel <= 1'b1;
        haddr <= a;
        hwrite <= 1'b0;
        htrans <= 2'b10;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'b00;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        d = hrdata[15:0];
    endtask

    // Only ever called with the channel disabled, reserved bits zero
    task set_ch(input int n, input logic [25:0] s, input logic [25:0] d,
                input logic [15:0] c, input logic [15:0] adc);
        ahb_wr(n * 32, s[15:0]);
        ahb_wr(n * 32 + 4, {6'h00, s[25:16]});
        ahb_wr(n * 32 + 8, d[15:0]);
        ahb_wr(n * 32 + 12, {6'h00, d[25:16]});
        ahb_wr(n * 32 + 16, c);
        ahb_wr(n * 32 + 20, adc);
    endtask

    task t_regs;
        logic [15:0] r;
        for (int i = 0; i < 7; i++) begin
            ahb_rd(32'h60 + 4 * i, r);
            chk(r, 16'h0000, "reset value");
        end
        ahb_wr(32'h74, 16'hffff);
        ahb_rd(32'h74, r);
        chk(r, 16'h40f0, "addressing control reserved bits");
        ahb_wr(32'h74, 16'h0000);
        ahb_wr(32'h78, 16'h0082);
        ahb_rd(32'h78, r);
        chk(r, 16'h0000, "flag and trigger not readable");
        ahb_wr(32'h70, 16'h0033);
        ahb_rd(32'h50, r);
        chk(r, 16'h0000, "count leaked to other channel");
        ahb_rd(32'h70, r);
        chk(r, 16'h0033, "count readback");
        ahb_wr(32'h1c, 16'h1234);
        ahb_rd(32'h1c, r);
        chk(r, 16'h0000, "unmapped read");
    endtask

    // Two 8-bit items by soft trigger, odd source stepping down, then the interrupt path
    task t_xfer8;
        logic [15:0] r;
        set_ch(0, 26'h101, 26'h200, 16'h0001, 16'h0040);
        r = 16'h0000;
        for (int i = 0; i < 4 && !r[7]; i++) begin
            ahb_wr(32'h18, 16'h0003);
            repeat (12) @(posedge hclk);
            ahb_rd(32'h18, r);
        end
        chk(r, 16'h0080, "flag set and enable clear");
        chk({8'h00, u_mem.mem[10'h200]}, 16'h005b, "first byte");
        chk({8'h00, u_mem.mem[10'h201]}, 16'h005a, "second byte");
        ahb_rd(32'h80, r);
        chk(r, 16'h0001, "status bit");
        chk({15'h0000, irq}, 16'h0000, "masked interrupt");
        ahb_wr(32'h84, 16'h0001);
        repeat (2) @(posedge hclk);
        chk({15'h0000, irq}, 16'h0001, "unmasked interrupt");
        ahb_wr(32'h80, 16'h0001);
        repeat (2) @(posedge hclk);
        chk({15'h0000, irq}, 16'h0000, "interrupt after clear");
    endtask

    // One 16-bit item by hardware request from odd addresses
    task t_xfer16;
        logic [15:0] r;
        set_ch(1, 26'h303, 26'h401, 16'h0000, 16'h4000);
        ahb_wr(32'h38, 16'h0001);
        dma_req <= 4'h2;
        @(posedge hclk);
        dma_req <= 4'h0;
        repeat (20) @(posedge hclk);
        ahb_rd(32'h38, r);
        chk(r, 16'h0080, "16-bit done");
        chk({8'h00, u_mem.mem[10'h400]}, 16'h0058, "aligned low byte");
        chk({8'h00, u_mem.mem[10'h401]}, 16'h0059, "aligned high byte");
    endtask

    // Init disables the channel so a later request moves nothing
    task t_init;
        logic [15:0] r;
        set_ch(2, 26'h010, 26'h300, 16'h0000, 16'h0000);
        ahb_wr(32'h58, 16'h0001);
        ahb_wr(32'h58, 16'h0004);
        ahb_rd(32'h58, r);
        chk(r, 16'h0000, "init disables");
        dma_req <= 4'h4;
        @(posedge hclk);
        dma_req <= 4'h0;
        repeat (20) @(posedge hclk);
        chk({8'h00, u_mem.mem[10'h300]}, 16'h005a, "no copy after init");
    endtask

    initial begin
        hresetn = 1'b0;
        hsel = 1'b0;
        haddr = 32'h00000000;
        htrans = 2'b00;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h00000000;
        dma_req = 4'h0;
        mismatches = 0;
        n_checks = 0;
        repeat (4) @(posedge hclk);
        hresetn <= 1'b1;
        t_regs;
        t_xfer8;
        t_xfer16;
        t_init;
        summarize;
    end

    // Whole run needs a few hundred cycles
    initial begin
        #2000000;
        mismatches++;
        summarize;
    end
endmodule

bind dma_ctrl dma_ctrl_assertions #(.NCH(NCH), .ADDR_W(ADDR_W)) u_chk (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .dma_req(dma_req),
    .irq(irq), .mem_req(mem_req), .mem_write(mem_write), .mem_addr(mem_addr),
    .mem_size(mem_size), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata),
    .mem_ready(mem_ready));
